/* pkg/fcs_pkg.sv */
// Purpose: constants for the flash command sequencer
// Assumes: 16-bit CPU address, 8-bit data, 100 MHz mclk
// Notes: APB register offsets are byte addresses
package fcs_pkg;
	localparam int CLK_MHZ = 100;
	localparam int PROG_US = 40;
	localparam int SECT_MS = 30;
	localparam int CHIP_MS = 30;
	localparam int PROG_CYC = PROG_US * CLK_MHZ;
	localparam int SECT_CYC = SECT_MS * 1000 * CLK_MHZ;
	localparam int CHIP_CYC = CHIP_MS * 1000 * CLK_MHZ;
	localparam logic [11:0] ADR_UNL1 = 12'h555;
	localparam logic [11:0] ADR_UNL2 = 12'hAAA;
	localparam logic [15:0] ADR_SEC = 16'hFF7F;
	localparam logic [15:0] ADR_VEND = 16'hF000;
	localparam logic [15:0] ADR_MACRO = 16'hF001;
	localparam logic [15:0] ADR_SIZE = 16'hF002;
	localparam logic [7:0] DAT_UNL1 = 8'hAA;
	localparam logic [7:0] DAT_UNL2 = 8'h55;
	localparam logic [7:0] CMD_PROG = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_SECT = 8'h30;
	localparam logic [7:0] CMD_CHIP = 8'h10;
	localparam logic [7:0] CMD_IDENT = 8'h90;
	localparam logic [7:0] CMD_EXIT = 8'hF0;
	localparam logic [7:0] CMD_SECUR = 8'hA5;
	localparam logic [7:0] DAT_SECUR = 8'h00;
	localparam logic [7:0] ERASED = 8'hFF;
	localparam logic [7:0] SEC_ON = 8'h00;
	localparam logic [3:0] UNLOCK_EN = 4'h3;
	localparam logic [3:0] UNLOCK_RST = 4'hC;
	localparam int TOG_BIT = 6;
	localparam logic [7:0] VENDOR_ID = 8'h5A; // Arbitrary value
	localparam logic [7:0] MACRO_ID = 8'h3C; // Arbitrary value
	localparam logic [7:0] SIZE_60K = 8'h0E;
	localparam logic [7:0] SIZE_48K = 8'h0B;
	localparam logic [7:0] SIZE_32K = 8'h07;
	localparam logic [7:0] SIZE_24K = 8'h05;
	localparam logic [7:0] SIZE_16K = 8'h03;
	localparam logic [7:0] SIZE_8K = 8'h01;
	localparam logic [7:0] SIZE_4K = 8'h00;
	localparam logic [11:0] REG_CTRL = 12'h000;
	localparam logic [11:0] REG_STAT = 12'h004;
	localparam int CTRL_UNL_LSB = 4;
	localparam int CTRL_BANK = 3;
	localparam int STAT_BUSY = 0;
	localparam int STAT_IDENT = 1;
	localparam int STAT_PROT = 2;
	localparam int STAT_OP_LSB = 4;
	typedef enum logic [2:0] {OP_NONE, OP_PROG, OP_SECT, OP_CHIP, OP_SECUR} fcs_op_t;
endpackage

/* verilog/fcs_seq.sv */
// Overview of operation
// - Command addresses compare only low 12 bits; upper 4 bits select area. Here the 00H security write must match FF7F in all 16 bits.
// - Byte program: AA@555, 55@AAA, A0@555, then address and data.
// - Sector erase: six writes ending 30H; upper address nibble picks sector.
// - Chip erase ends 10H at 555; whole array then reads FFH.
// - Byte program finishes within 40 us after last write.
// - Sector erase finishes within 30 ms after sixth write.
// - Chip erase finishes in about 30 ms.
// - No new command sequence accepted while an operation runs.
// - While busy, repeated reads of same address invert data bit 6.
// - First toggle-bit read after program, chip erase or security is one.
// - Unlock pair then 90H at 555 enters product ID mode.
// - ID mode returns vendor, macro, size and security status codes.
// - Size code maps array size, 0EH for 60 kbytes.
// - Security status reads FFH when off, other value when on.
// - ID mode left by F0H anywhere, or unlock pair plus F0H at 555.
// - Security program: unlock pair, A5H at 555, 00H at FF7F.
// - Protection flag blocks PROM-mode reads and serial writes; here prot_ff only drives prot_on, the status register bit and the security status code.
// - Only chip erase clears protection; here rst also clears prot_ff.
// - Security program finishes within 40 us, toggle-bit signalled.
// - Sequences ignored unless unlock field is 0011B; reset loads 1100B.
//
// Purpose: decode CPU write sequences for the on-chip flash, time operations
// Assumes: CPU bus single-cycle strobes synchronous to mclk
// Notes: flash array itself is outside; this block issues program/erase pulses
//
// The implementer's own choices: register access over APB and the address map.
`timescale 1ns/1ps
module fcs_seq
	import fcs_pkg::*;
(
	input wire logic mclk, // System clock
	input wire logic rst, // Synchronous reset
	input wire logic cpu_wr, // CPU flash write strobe
	input wire logic cpu_rd, // CPU flash read strobe
	input wire logic [15:0] cpu_addr, // CPU address
	input wire logic [7:0] cpu_wdata, // CPU write data
	input wire logic [7:0] arr_rdata, // Array read data
	input wire logic [2:0] size_sel, // Array size select
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [11:0] paddr, // APB address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	output logic [7:0] cpu_rdata, // Data back to CPU
	output logic arr_prog, // Program pulse to array
	output logic arr_sect, // Sector erase pulse
	output logic arr_chip, // Chip erase pulse
	output logic [15:0] arr_addr, // Array target address
	output logic [7:0] arr_wdata, // Array program data
	output logic prot_on, // Security protection active
	output logic busy // Operation in progress
);
	// ----------------------------------------
	// Decode state
	// ----------------------------------------
	typedef enum logic [3:0] {S_IDLE, S_U1, S_U2, S_PROG, S_E1, S_E2, S_E3, S_SEC} fcs_st_t;
	fcs_st_t st_ff, nxt_st;
	logic [3:0] unlock_ff;
	logic bank_ff;
	logic ident_ff, nxt_ident;
	logic prot_ff, nxt_prot;
	fcs_op_t op_ff, nxt_op;
	logic [31:0] cnt_ff, nxt_cnt;
	logic tog_ff;
	logic [15:0] last_rd_ff;
	logic first_ff;
	logic [31:0] prdata_ff;
	logic [7:0] rdata_ff;
	logic prog_ff, sect_ff, chip_ff;
	logic [15:0] aaddr_ff;
	logic [7:0] awdata_ff;

	// Upper nibble ignored: it only picks the flash area
	function automatic logic hit(input logic [15:0] a, input logic [11:0] low, input logic [7:0] d,
		input logic [7:0] want);
		hit = (a[11:0] == low) && (d == want);
	endfunction

	wire cmd_ok = unlock_ff == UNLOCK_EN;
	wire is_busy = op_ff != OP_NONE;
	wire wr_go = cpu_wr && cmd_ok && !is_busy;
	wire w_u1 = hit(cpu_addr, ADR_UNL1, cpu_wdata, DAT_UNL1);
	wire w_u2 = hit(cpu_addr, ADR_UNL2, cpu_wdata, DAT_UNL2);
	wire at555 = cpu_addr[11:0] == ADR_UNL1;
	wire exit1 = ident_ff && cpu_wdata == CMD_EXIT;

	// ----------------------------------------
	// Sequence decoder
	// ----------------------------------------
	always_comb
	begin
		nxt_st = st_ff;
		nxt_ident = ident_ff;
		nxt_op = op_ff;
		nxt_prot = prot_ff;
		nxt_cnt = cnt_ff;
		if (is_busy)
		begin
			if (cnt_ff == 32'h0000_0000)
			begin
				nxt_op = OP_NONE;
				if (op_ff == OP_SECUR)
					nxt_prot = 1'b1;
				if (op_ff == OP_CHIP)
					nxt_prot = 1'b0;
			end
			else
				nxt_cnt = cnt_ff - 32'h0000_0001;
		end
		if (wr_go)
		begin
			nxt_st = S_IDLE;
			case (st_ff)
				S_IDLE:
					if (w_u1)
						nxt_st = S_U1;
					else if (exit1)
						nxt_ident = 1'b0;
				S_U1:
					if (w_u2)
						nxt_st = S_U2;
				S_U2:
					if (at555)
						case (cpu_wdata)
							CMD_PROG: nxt_st = S_PROG;
							CMD_ERASE: nxt_st = S_E1;
							CMD_IDENT: nxt_ident = 1'b1;
							CMD_EXIT: nxt_ident = 1'b0;
							CMD_SECUR: nxt_st = S_SEC;
							default: nxt_st = S_IDLE;
						endcase
				S_PROG:
				begin
					nxt_op = OP_PROG;
					nxt_cnt = 32'(PROG_CYC - 1);
				end
				S_E1:
					if (w_u1)
						nxt_st = S_E2;
				S_E2:
					if (w_u2)
						nxt_st = S_E3;
				S_E3:
					if (cpu_wdata == CMD_SECT)
					begin
						nxt_op = OP_SECT;
						nxt_cnt = 32'(SECT_CYC - 1);
					end
					else if (at555 && cpu_wdata == CMD_CHIP)
					begin
						nxt_op = OP_CHIP;
						nxt_cnt = 32'(CHIP_CYC - 1);
					end
				S_SEC:
					if (cpu_addr == ADR_SEC && cpu_wdata == DAT_SECUR)
					begin
						nxt_op = OP_SECUR;
						nxt_cnt = 32'(PROG_CYC - 1);
					end
				default: nxt_st = S_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	logic [7:0] size_code;
	always_comb
	begin
		case (size_sel)
			3'h0: size_code = SIZE_60K;
			3'h1: size_code = SIZE_48K;
			3'h2: size_code = SIZE_32K;
			3'h3: size_code = SIZE_24K;
			3'h4: size_code = SIZE_16K;
			3'h5: size_code = SIZE_8K;
			default: size_code = SIZE_4K;
		endcase
	end
	wire [7:0] sec_code = prot_ff ? SEC_ON : ERASED;
	wire [7:0] id_data = (cpu_addr == ADR_VEND) ? VENDOR_ID :
		(cpu_addr == ADR_MACRO) ? MACRO_ID :
		(cpu_addr == ADR_SIZE) ? size_code :
		(cpu_addr == ADR_SEC) ? sec_code : arr_rdata;
	wire same_rd = !first_ff && cpu_addr == last_rd_ff;
	wire nxt_tog = same_rd ? !tog_ff : 1'b1;
	wire [7:0] busy_data = {arr_rdata[7], nxt_tog, arr_rdata[5:0]};
	wire [7:0] rd_mux = is_busy ? busy_data : ident_ff ? id_data : arr_rdata;

	wire apb_acc = psel && penable;
	wire ctrl_hit = paddr == REG_CTRL;
	wire stat_hit = paddr == REG_STAT;
	// Low control bits read as zero
	wire [31:0] ctrl_val = {24'h00_0000, unlock_ff, bank_ff, 3'h0};
	wire [31:0] stat_val = {25'h000_0000, op_ff, 1'b0, prot_ff, ident_ff, is_busy};
	// Read data loaded in setup so it stands at the access edge
	wire apb_setup_rd = psel && !penable && !pwrite;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			st_ff <= S_IDLE;
			ident_ff <= 1'b0;
			prot_ff <= 1'b0;
			op_ff <= OP_NONE;
			cnt_ff <= 32'h0000_0000;
			unlock_ff <= UNLOCK_RST;
			bank_ff <= 1'b1;
			tog_ff <= 1'b0;
			first_ff <= 1'b1;
			last_rd_ff <= 16'h0000;
			rdata_ff <= 8'h00;
			prdata_ff <= 32'h0000_0000;
			prog_ff <= 1'b0;
			sect_ff <= 1'b0;
			chip_ff <= 1'b0;
			aaddr_ff <= 16'h0000;
			awdata_ff <= 8'h00;
		end
		else
		begin
			st_ff <= nxt_st;
			ident_ff <= nxt_ident;
			prot_ff <= nxt_prot;
			op_ff <= nxt_op;
			cnt_ff <= nxt_cnt;
			prog_ff <= wr_go && st_ff == S_PROG;
			sect_ff <= wr_go && nxt_op == OP_SECT && !is_busy;
			chip_ff <= wr_go && nxt_op == OP_CHIP && !is_busy;
			if (wr_go && (st_ff == S_PROG || st_ff == S_E3))
			begin
				aaddr_ff <= cpu_addr;
				awdata_ff <= cpu_wdata;
			end
			if (cpu_rd)
			begin
				rdata_ff <= rd_mux;
				last_rd_ff <= cpu_addr;
				tog_ff <= nxt_tog;
				first_ff <= !is_busy;
			end
			else if (!is_busy)
				first_ff <= 1'b1;
			if (apb_acc && pwrite && ctrl_hit)
			begin
				unlock_ff <= pwdata[CTRL_UNL_LSB +: 4];
				bank_ff <= pwdata[CTRL_BANK];
			end
			if (apb_setup_rd)
				prdata_ff <= ctrl_hit ? ctrl_val : stat_hit ? stat_val : 32'h0000_0000;
		end
	end

	assign prdata = prdata_ff;
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign cpu_rdata = rdata_ff;
	assign arr_prog = prog_ff;
	assign arr_sect = sect_ff;
	assign arr_chip = chip_ff;
	assign arr_addr = aaddr_ff;
	assign arr_wdata = awdata_ff;
	assign prot_on = prot_ff;
	assign busy = op_ff != OP_NONE;

	// ----------------------------------------
	// Checks: decoder
	// ----------------------------------------
	locked_ignore_a: assert property (@(posedge mclk) disable iff (rst)
		cpu_wr && unlock_ff != UNLOCK_EN |=> st_ff == $past(st_ff))
		else $error("write accepted while locked");
	busy_block_a: assert property (@(posedge mclk) disable iff (rst)
		is_busy && cpu_wr |=> st_ff == $past(st_ff))
		else $error("sequence advanced while busy");
	prog_time_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_ff) |-> op_ff == OP_PROG && cnt_ff == 32'(PROG_CYC - 1))
		else $error("program time wrong");
	first_tog_a: assert property (@(posedge mclk) disable iff (rst)
		is_busy && cpu_rd && first_ff |=> rdata_ff[TOG_BIT])
		else $error("first toggle read not one");
	toggle_rd_a: assert property (@(posedge mclk) disable iff (rst)
		is_busy && cpu_rd && same_rd |=> rdata_ff[TOG_BIT] != $past(rdata_ff[TOG_BIT]))
		else $error("toggle bit stuck");

	chip_clear_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(prot_ff) |-> $past(op_ff) == OP_CHIP)
		else $error("protection cleared without chip erase");
	prot_set_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prot_ff) |-> $past(op_ff) == OP_SECUR)
		else $error("protection set without security program");
	ident_enter_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(ident_ff) |-> $past(st_ff) == S_U2 && $past(cpu_wdata) == CMD_IDENT)
		else $error("id mode entered wrongly");

	ident_exit_a: assert property (@(posedge mclk) disable iff (rst)
		$fell(ident_ff) |-> $past(cpu_wr) && $past(cpu_wdata) == CMD_EXIT)
		else $error("id mode left without exit code");

	unlock_abort_a: assert property (@(posedge mclk) disable iff (rst)
		wr_go && st_ff == S_U1 && !w_u2 |=> st_ff == S_IDLE)
		else $error("bad second unlock not aborted");

	prog_data_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(prog_ff) |-> awdata_ff == $past(cpu_wdata) && aaddr_ff == $past(cpu_addr))
		else $error("program target not latched");

	prog_single_a: assert property (@(posedge mclk) disable iff (rst)
		prog_ff |=> !prog_ff)
		else $error("program pulse longer than one cycle");

	sect_addr_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(sect_ff) |-> aaddr_ff == $past(cpu_addr))
		else $error("sector address not latched");

	chip_addr_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(chip_ff) |-> $past(cpu_addr[11:0]) == ADR_UNL1)
		else $error("chip erase from wrong address");

	// ----------------------------------------
	// Checks: timing
	// ----------------------------------------
	// Full erase spans are too long to unroll, so the
	// load value and the count-down steps are checked instead
	sect_time_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(sect_ff) |-> op_ff == OP_SECT && cnt_ff == 32'(SECT_CYC - 1))
		else $error("sector erase time wrong");

	chip_time_a: assert property (@(posedge mclk) disable iff (rst)
		$rose(chip_ff) |-> op_ff == OP_CHIP && cnt_ff == 32'(CHIP_CYC - 1))
		else $error("chip erase time wrong");

	count_step_a: assert property (@(posedge mclk) disable iff (rst)
		is_busy && cnt_ff != 32'h0000_0000 |=> cnt_ff == $past(cnt_ff) - 32'h0000_0001)
		else $error("operation counter skipped");

	busy_end_a: assert property (@(posedge mclk) disable iff (rst)
		is_busy && cnt_ff == 32'h0000_0000 |=> !is_busy)
		else $error("operation outlived its counter");

	// ----------------------------------------
	// Checks: read data
	// ----------------------------------------
	vend_read_a: assert property (@(posedge mclk) disable iff (rst)
		ident_ff && !is_busy && cpu_rd && cpu_addr == ADR_VEND |=> rdata_ff == VENDOR_ID)
		else $error("vendor code wrong");

	sec_read_a: assert property (@(posedge mclk) disable iff (rst)
		ident_ff && !is_busy && cpu_rd && cpu_addr == ADR_SEC
		|=> rdata_ff == ($past(prot_ff) ? SEC_ON : ERASED))
		else $error("security status wrong");
endmodule

/* test/fcs_cpu_model.sv */
// Purpose: CPU core model issuing flash bus cycles
// Assumes: one-cycle strobes launched after mclk rises
// Notes: released address and data show inverted values
`timescale 1ns/1ps
module fcs_cpu_model
(
	input wire logic mclk, // Clock
	input wire logic [7:0] rdata, // Read data
	output logic wr = 1'b0, // Write strobe
	output logic rd = 1'b0, // Read strobe
	output logic [15:0] addr = 16'h0000, // Address
	output logic [7:0] wdata = 8'h00 // Write data
);
	task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
		rd <= 1'b0;
		addr <= ~a; // Stale bus must not pass for valid
		wdata <= ~d;
	endtask
	task automatic rdb(input logic [15:0] a, output logic [7:0] q);
		bus(1'b0, a, 8'h00);
		@(negedge mclk);
		q = rdata;
	endtask
	// Polls one address until two reads agree
	task automatic poll(input logic [15:0] a, input int lim, output logic ok);
		logic [7:0] p;
		logic [7:0] q;
		ok = 1'b0;
		rdb(a, p);
		for (int i = 0; i < lim && !ok; i++)
		begin
			rdb(a, q);
			ok = q === p;
			p = q;
		end
	endtask
endmodule

/* test/fcs_seq_bench.sv */
// Purpose: self-checking bench for fcs_seq
// Assumes: erase timers outlast the run, reset ends them
// Notes: expected values come from the package and from literals in the bench
`timescale 1ns/1ps
module fcs_seq_bench
	import fcs_pkg::*;
;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [7:0] arr_rdata = 8'h81;
	logic [2:0] size_sel = 3'h0;
	logic cpu_wr, cpu_rd, pready, pslverr, arr_prog, arr_sect, arr_chip, prot_on, busy;
	logic [15:0] cpu_addr, arr_addr;
	logic [7:0] cpu_wdata, cpu_rdata, arr_wdata, b;
	logic [31:0] prdata, q;
	logic ok;
	int failures = 0;
	int checks_done = 0;
	int n_prog = 0, n_sect = 0, n_chip = 0;
	typedef struct packed {logic [2:0] sz; logic [15:0] a; logic [7:0] e;} fcs_row_t;
	fcs_row_t rows [11] = '{'{3'h0, 16'hF002, 8'h0E}, '{3'h1, 16'hF002, 8'h0B},
		'{3'h2, 16'hF002, 8'h07}, '{3'h3, 16'hF002, 8'h05}, '{3'h4, 16'hF002, 8'h03},
		'{3'h5, 16'hF002, 8'h01}, '{3'h6, 16'hF002, 8'h00}, '{3'h7, 16'hF002, 8'h00},
		'{3'h0, 16'hF000, VENDOR_ID}, '{3'h0, 16'hF001, MACRO_ID}, '{3'h0, 16'hFF7F, 8'hFF}};
	always #5 mclk = ~mclk;
	always @(posedge mclk)
	begin
		n_prog <= n_prog + arr_prog;
		n_sect <= n_sect + arr_sect;
		n_chip <= n_chip + arr_chip;
	end
	fcs_seq fcs_seq_inst(.mclk, .rst, .cpu_wr, .cpu_rd, .cpu_addr, .cpu_wdata, .arr_rdata, .size_sel,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .cpu_rdata,
		.arr_prog, .arr_sect, .arr_chip, .arr_addr, .arr_wdata, .prot_on, .busy);
	fcs_cpu_model fcs_cpu_model_inst(.mclk, .rdata(cpu_rdata), .wr(cpu_wr), .rd(cpu_rd),
		.addr(cpu_addr), .wdata(cpu_wdata));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			failures++;
			$display("Error %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge mclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge mclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		if (n >= 50)
		begin
			failures++;
			end_of_test();
		end
		q = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset();
		@(posedge mclk);
		rst <= 1'b1;
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
	endtask
	task automatic w(input logic [15:0] a, input logic [7:0] d);
		fcs_cpu_model_inst.bus(1'b1, a, d);
	endtask
	task automatic r(input logic [15:0] a);
		fcs_cpu_model_inst.rdb(a, b);
	endtask
	// Unlock pair then command at 555, with high nibbles that must be ignored
	task automatic c(input logic [7:0] d);
		w(16'hF555, DAT_UNL1);
		w(16'h3AAA, DAT_UNL2);
		w(16'h9555, d);
	endtask
	task automatic settle();
		repeat (3) @(negedge mclk);
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		do_reset();
		apb(1'b0, REG_CTRL, 32'h0);
		chk("ctrl", 32'h000000C8, q);
		c(CMD_PROG);
		w(16'h3456, 8'h5A);
		settle();
		chk("locked", 0, n_prog);
		apb(1'b1, REG_CTRL, 32'h00000030);
		apb(1'b0, 12'h010, 32'h0);
		chk("unmapped", 0, q);
		$display("test reset done");
		c(CMD_IDENT);
		for (int i = 0; i < 11; i++)
		begin
			@(posedge mclk);
			size_sel <= rows[i].sz;
			r(rows[i].a);
			chk("ident", rows[i].e, b);
		end
		w(16'h1234, CMD_EXIT);
		r(16'h3000);
		chk("exit", 8'h81, b);
		w(16'hF555, DAT_UNL1);
		w(16'hFAA0, DAT_UNL2);
		w(16'hF555, CMD_PROG);
		w(16'h2345, 8'h77);
		settle();
		chk("abort", 0, n_prog);
		$display("test ident done");
		c(CMD_PROG);
		w(16'h3456, 8'h5A);
		settle();
		chk("prog", 1, n_prog);
		chk("addr", 16'h3456, arr_addr);
		chk("wdata", 8'h5A, arr_wdata);
		r(16'h3456);
		chk("tog1", 8'hC1, b);
		r(16'h3456);
		chk("tog2", 8'h81, b);
		c(CMD_PROG);
		w(16'h1111, 8'h22);
		settle();
		chk("busyblk", 1, n_prog);
		fcs_cpu_model_inst.poll(16'h3456, PROG_CYC, ok);
		chk("progdone", 2'b10, {ok, busy});
		$display("test program done");
		c(CMD_SECUR);
		w(ADR_SEC, DAT_SECUR);
		settle();
		r(16'h3000);
		chk("sectog", 8'hC1, b);
		fcs_cpu_model_inst.poll(16'h3000, PROG_CYC, ok);
		chk("secdone", 3'b101, {ok, busy, prot_on});
		c(CMD_IDENT);
		r(ADR_SEC);
		chk("secstat", SEC_ON, b);
		c(CMD_EXIT);
		r(16'h3000);
		chk("exit2", 8'h81, b);
		$display("test security done");
		c(CMD_ERASE);
		w(16'hF555, DAT_UNL1);
		w(16'hFAAA, DAT_UNL2);
		w(16'h7ABC, CMD_SECT);
		settle();
		chk("sect", 1, n_sect);
		chk("sectnib", 4'h7, arr_addr[15:12]);
		chk("protkeep", 2'b11, {prot_on, busy});
		do_reset();
		apb(1'b1, REG_CTRL, 32'h00000030);
		c(CMD_ERASE);
		c(CMD_CHIP);
		settle();
		chk("chip", 1, n_chip);
		r(16'h3000);
		chk("chiptog", 8'hC1, b);
		$display("test erase done");
		end_of_test();
	end
endmodule
